// File: rtl/crc_regs.svh
// Register offsets, field positions, reset values and timing figures of the
// charge rationing controller. Included by the package and the design files.
`ifndef CRC_REGS_SVH
`define CRC_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CRC_OFS_CTRL 8'h00
`define CRC_OFS_LIMIT 8'h04
`define CRC_OFS_STATUS 8'h08
`define CRC_OFS_CHARGE 8'h0c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CRC_CTRL_EN_BIT 0
`define CRC_CTRL_ACT_LSB 1
`define CRC_CTRL_ACT_MSB 2
`define CRC_CTRL_RST_BIT 3
`define CRC_STAT_FLAG_BIT 0
`define CRC_STAT_ATTN_BIT 1
`define CRC_STAT_ST_LSB 2
`define CRC_STAT_ST_MSB 3
`define CRC_LIMIT_W 16
`define CRC_CUR_W 12
`define CRC_PIN_W 5

// Pin positions inside the synchronised control pin vector.
`define CRC_PIN_MODE_LO 0
`define CRC_PIN_MODE_HI 1
`define CRC_PIN_EMU 2
`define CRC_PIN_STBY 3
`define CRC_PIN_PWR 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CRC_RST_ACT 2'h1
`define CRC_RST_LIMIT 16'hffff

// ----------------------------------------------------------------------------
// Timing: the charge is summed once per tick, in mA, and one mAh is
// 3600000 mA-ms.
// ----------------------------------------------------------------------------
`define CRC_CLK_NS 40
`define CRC_TICK_NS 1000000
`define CRC_TICK_CYCLES (`CRC_TICK_NS / `CRC_CLK_NS)
`define CRC_TICKS_PER_MAH 3600000

`endif

// File: rtl/crc_pkg.sv
// Types shared by the charge rationing controller files.
// Assumes crc_regs.svh sits on the include path.
package crc_pkg;
   `include "crc_regs.svh"

   typedef enum logic [1:0] {
      CRC_ACT_REPORT = 2'h0,
      CRC_ACT_RPT_DISC = 2'h1,
      CRC_ACT_DISC_SLEEP = 2'h2,
      CRC_ACT_IGNORE = 2'h3
   } crc_action_type;

   // Gray codes along idle -> run -> held.
   typedef enum logic [1:0] {
      CRC_ST_IDLE = 2'h0,
      CRC_ST_RUN = 2'h1,
      CRC_ST_HELD = 2'h3
   } crc_state_type;
endpackage

// File: rtl/crc_acc_if.sv
// Carrier between the rationing controller and its charge accumulator.
// Assumes both ends sit on the same clock.
interface crc_acc_if;
   logic run;
   logic clear;
   logic restart;
   logic [11:0] current_ma;
   logic [15:0] limit;
   logic [15:0] charge;
   logic at_limit;
   modport ctl (output run, output clear, output restart, output current_ma, output limit,
                input charge, input at_limit);
   modport acc (input run, input clear, input restart, input current_ma, input limit,
                output charge, output at_limit);
endinterface

// File: rtl/crc_accum.sv
// Charge accumulator: sums the sensed current once per tick and counts mAh.
// Assumes the current sample is already on this clock.
`include "crc_regs.svh"
module crc_accum
   import crc_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `CRC_TICK_CYCLES,
   parameter int unsigned TICKS_PER_MAH = `CRC_TICKS_PER_MAH
) (
   input wire logic clock,
   input wire logic sys_rst,
   crc_acc_if.acc acc
);
   logic [31:0] tick_q;
   logic [31:0] resid_q;
   logic [15:0] charge_q;
   logic tick;
   logic [31:0] sum;

   assign tick = acc.run && (tick_q == 32'(TICK_CYCLES - 1));
   assign sum = resid_q + {20'h0, acc.current_ma};

   // ---------------------------------------------------------------------------
   // Tick timer
   // ---------------------------------------------------------------------------
   // A limit update restarts the interval so time is measured from the update.
   always_ff @(posedge clock) begin
      if (sys_rst || acc.clear || acc.restart || !acc.run || tick) begin
         tick_q <= 32'h0;
      end else begin
         tick_q <= tick_q + 32'h1;
      end
   end

   // ---------------------------------------------------------------------------
   // Charge sum
   // ---------------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst || acc.clear) begin
         resid_q <= 32'h0;
         charge_q <= 16'h0;
      end else if (tick) begin // [R3]
         if (sum >= 32'(TICKS_PER_MAH)) begin
            resid_q <= sum - 32'(TICKS_PER_MAH);
            if (charge_q != 16'hffff) begin
               charge_q <= charge_q + 16'h1;
            end
         end else begin
            resid_q <= sum;
         end
      end
   end

   assign acc.charge = charge_q;
   assign acc.at_limit = (charge_q >= acc.limit); // [R4]

   property p_clear_zero;
      @(posedge clock) disable iff (sys_rst) acc.clear |=> (charge_q == 16'h0) && (resid_q == 32'h0);
   endproperty
   a_clear_zero: assert property (p_clear_zero) else $error("charge not cleared"); // [R16]

   property p_no_loss;
      @(posedge clock) disable iff (sys_rst)
         !acc.clear && !$past(acc.clear) |-> charge_q >= $past(charge_q);
   endproperty
   a_no_loss: assert property (p_no_loss) else $error("charge went down"); // [R3]
endmodule // crc_accum

// File: rtl/crc_top.sv
// Charge rationing controller: AHB-Lite register slave, threshold actions,
// recovery sequencing and control pin re-check.
// Assumes current_ma, active_state and the detect events come from logic on
// this clock; the five control pins come straight from the package pins.
//
// Functional notes
// [R1] Host programs the mAh limit when enabled.
// [R2] Rationing runs only in Active power state.
// [R3] Accumulate current over time into charge.
// [R4] Continuously compare charge against limit.
// [R5] Threshold never forces the Error state.
// [R6] Two-bit selector picks action; default 01.
// [R7] Report-disconnect: attention, drop emulation, open switch.
// [R8] Report-disconnect: switch off until rationing reset.
// [R9] Report-disconnect: bypass switch stays off.
// [R10] Disconnect-sleep: open, drop emulation, sleep, stop monitors.
// [R11] Disconnect-sleep: control pin changes are ignored.
// [R12] Hold action until reset; reset/disable recovers.
// [R13] Report reset: clear charge, flag, attention.
// [R14] Report-disconnect reset: clear, release, re-check pins.
// [R15] Disconnect-sleep reset: clear, then re-check pins.
// [R16] Ignore reset: clear charge and flag only.
// [R17] Changed pins restart emulation if enabled.
// [R18] Unchanged pins resume previous state quietly.
// [R19] Detach/attach keep charge; attach restarts emulation (here only after a removal and while in the RUN state).
// [R20] New action after threshold applies at once.
// [R21] Action change leaves charge data untouched.
// [R22] Flag sets on reaching limit, every mode.
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`include "crc_regs.svh"
module crc_top
   import crc_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `CRC_TICK_CYCLES,
   parameter int unsigned TICKS_PER_MAH = `CRC_TICKS_PER_MAH
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [11:0] current_ma,
   input wire logic active_state,
   input wire logic removal_event,
   input wire logic attach_event,
   input wire logic mode_select_lo,
   input wire logic mode_select_hi,
   input wire logic emulation_enable_pin,
   input wire logic standby_bypass_ctl,
   input wire logic port_power_enable_pin,
   output logic host_attn_n,
   output logic emu_profile_remove,
   output logic port_switch_force_off,
   output logic bypass_switch_block,
   output logic sleep_request,
   output logic data_line_switch_disable,
   output logic bus_monitor_stop,
   output logic ctl_pins_ignored,
   output logic power_state_reeval,
   output logic resume_prev_state,
   output logic emu_restart
);
   // ---------------------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------------------
   crc_acc_if acc_bus ();

   logic [4:0] pins_meta_q;
   logic [4:0] pins_sync_q;
   logic [4:0] snap_q;
   logic ap_valid_q;
   logic ap_write_q;
   logic [7:0] ap_addr_q;
   logic [31:0] hrdata_q;
   logic enable_q;
   crc_action_type action_q;
   crc_action_type action_new;
   logic [15:0] limit_q;
   crc_state_type state_q;
   crc_state_type state_d;
   logic reached_q;
   logic removed_q;
   logic reeval_q;
   logic resume_q;
   logic emu_restart_q;
   logic wr_ctrl;
   logic wr_limit;
   logic rst_evt;
   logic disable_evt;
   logic recover;
   logic act_change;
   logic check_evt;
   logic pins_changed;
   logic hit_limit;
   logic held;
   logic [31:0] rd_word;

   function automatic logic disc_mode(input crc_action_type a);
      disc_mode = (a == CRC_ACT_RPT_DISC) || (a == CRC_ACT_DISC_SLEEP);
   endfunction

   // ---------------------------------------------------------------------------
   // Control pin synchroniser
   // ---------------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pins_meta_q <= 5'h0;
         pins_sync_q <= 5'h0;
      end else begin
         pins_meta_q <= {port_power_enable_pin, standby_bypass_ctl, emulation_enable_pin,
                         mode_select_hi, mode_select_lo};
         pins_sync_q <= pins_meta_q;
      end
   end

   // ---------------------------------------------------------------------------
   // AHB-Lite slave
   // ---------------------------------------------------------------------------
   // Zero wait states: read data is fetched at the address phase so it stands
   // from a flip-flop for the whole data phase.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_addr_q <= 8'h0;
      end else if (hready) begin
         ap_valid_q <= hsel && htrans[1];
         ap_write_q <= hwrite;
         ap_addr_q <= haddr[7:0];
      end
   end

   always_comb begin
      rd_word = 32'h0;
      case (haddr[7:0])
         `CRC_OFS_CTRL: begin
            rd_word[`CRC_CTRL_EN_BIT] = enable_q;
            rd_word[`CRC_CTRL_ACT_MSB:`CRC_CTRL_ACT_LSB] = action_q;
         end
         `CRC_OFS_LIMIT: rd_word[15:0] = limit_q;
         `CRC_OFS_STATUS: begin
            rd_word[`CRC_STAT_FLAG_BIT] = reached_q;
            rd_word[`CRC_STAT_ATTN_BIT] = !host_attn_n;
            rd_word[`CRC_STAT_ST_MSB:`CRC_STAT_ST_LSB] = state_q;
         end
         `CRC_OFS_CHARGE: rd_word[15:0] = acc_bus.charge;
         default: rd_word = 32'h0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         hrdata_q <= 32'h0;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata_q <= rd_word;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   assign wr_ctrl = ap_valid_q && ap_write_q && (ap_addr_q == `CRC_OFS_CTRL);
   assign wr_limit = ap_valid_q && ap_write_q && (ap_addr_q == `CRC_OFS_LIMIT);
   assign rst_evt = wr_ctrl && hwdata[`CRC_CTRL_RST_BIT];
   assign disable_evt = wr_ctrl && enable_q && !hwdata[`CRC_CTRL_EN_BIT];
   assign action_new = crc_action_type'(hwdata[`CRC_CTRL_ACT_MSB:`CRC_CTRL_ACT_LSB]);
   assign act_change = wr_ctrl && (action_new != action_q);

   // ---------------------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------------------
   // The action select may change at any time; the outputs below follow it
   // in the next cycle and the charge data are not touched.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         enable_q <= 1'b0;
         action_q <= crc_action_type'(`CRC_RST_ACT); // [R6]
      end else if (wr_ctrl) begin
         enable_q <= hwdata[`CRC_CTRL_EN_BIT];
         action_q <= action_new; // [R20] [R21]
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         limit_q <= `CRC_RST_LIMIT;
      end else if (wr_limit) begin
         limit_q <= hwdata[15:0]; // [R1]
      end
   end

   // ---------------------------------------------------------------------------
   // Accumulator
   // ---------------------------------------------------------------------------
   assign acc_bus.run = (state_q == CRC_ST_RUN); // [R2]
   assign acc_bus.clear = rst_evt || disable_evt; // [R13] [R16]
   assign acc_bus.restart = wr_limit;
   assign acc_bus.current_ma = current_ma;
   assign acc_bus.limit = limit_q;

   crc_accum #(
      .TICK_CYCLES(TICK_CYCLES),
      .TICKS_PER_MAH(TICKS_PER_MAH)
   ) u_accum (
      .clock(clock),
      .sys_rst(sys_rst),
      .acc(acc_bus)
   );

   // ---------------------------------------------------------------------------
   // Rationing state machine
   // ---------------------------------------------------------------------------
   assign held = (state_q == CRC_ST_HELD);
   assign recover = held && (rst_evt || disable_evt); // [R12]
   assign hit_limit = (state_q == CRC_ST_RUN) && enable_q && active_state && acc_bus.at_limit;

   always_comb begin
      state_d = state_q;
      case (state_q)
         CRC_ST_IDLE: begin
            if (enable_q && active_state) begin
               state_d = CRC_ST_RUN;
            end
         end
         CRC_ST_RUN: begin
            if (!enable_q || !active_state) begin
               state_d = CRC_ST_IDLE; // [R2]
            end else if (acc_bus.at_limit) begin
               state_d = CRC_ST_HELD; // [R4]
            end
         end
         CRC_ST_HELD: begin
            // Sleep drops the Active state, so holding ignores active_state.
            if (recover) begin
               state_d = CRC_ST_IDLE; // [R12]
            end
         end
         default: state_d = CRC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= CRC_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // The flag is set by hardware and cleared by the recovery; set wins.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reached_q <= 1'b0;
      end else if (hit_limit) begin
         reached_q <= 1'b1; // [R22]
      end else if (recover) begin
         reached_q <= 1'b0; // [R13] [R14] [R15] [R16]
      end
   end

   // Pin levels are remembered at the threshold so a later recovery can tell
   // whether the host moved them meanwhile.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         snap_q <= 5'h0;
      end else if (hit_limit) begin
         snap_q <= pins_sync_q;
      end
   end

   // ---------------------------------------------------------------------------
   // Threshold actions
   // ---------------------------------------------------------------------------
   // No output here reaches the Error state logic.  [R5]
   assign host_attn_n = !(reached_q && ((action_q == CRC_ACT_REPORT) ||
                                        (action_q == CRC_ACT_RPT_DISC))); // [R7] [R13]
   assign emu_profile_remove = reached_q && disc_mode(action_q); // [R7] [R10]
   assign port_switch_force_off = reached_q && disc_mode(action_q); // [R8] [R10]
   assign bypass_switch_block = reached_q && (action_q == CRC_ACT_RPT_DISC); // [R9]
   assign sleep_request = reached_q && (action_q == CRC_ACT_DISC_SLEEP); // [R10]
   assign data_line_switch_disable = sleep_request; // [R10]
   assign bus_monitor_stop = sleep_request; // [R10]
   assign ctl_pins_ignored = sleep_request; // [R11]

   // ---------------------------------------------------------------------------
   // Pin re-check and emulation restart
   // ---------------------------------------------------------------------------
   assign pins_changed = (pins_sync_q != snap_q);
   assign check_evt = (recover && disc_mode(action_q)) ||
                      (held && act_change && disc_mode(action_q) &&
                       !disc_mode(action_new)); // [R14] [R15] [R20]

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         removed_q <= 1'b0;
      end else if (removal_event) begin
         removed_q <= 1'b1;
      end else if (attach_event) begin
         removed_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reeval_q <= 1'b0;
         resume_q <= 1'b0;
         emu_restart_q <= 1'b0;
      end else begin
         reeval_q <= check_evt && pins_changed; // [R14] [R15]
         resume_q <= check_evt && !pins_changed; // [R18]
         emu_restart_q <= (check_evt && pins_changed && pins_sync_q[`CRC_PIN_EMU]) ||
                          (attach_event && removed_q && !reached_q &&
                           (state_q == CRC_ST_RUN)); // [R17] [R19]
      end
   end

   assign power_state_reeval = reeval_q;
   assign resume_prev_state = resume_q;
   assign emu_restart = emu_restart_q;

   // ---------------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------------
   property p_report_attn;
      @(posedge clock) disable iff (sys_rst)
         reached_q && (action_q == CRC_ACT_REPORT) |-> !host_attn_n && !port_switch_force_off;
   endproperty
   a_report_attn: assert property (p_report_attn) else $error("report action wrong"); // [R6]

   property p_rd_switch;
      @(posedge clock) disable iff (sys_rst)
         reached_q && (action_q == CRC_ACT_RPT_DISC) |->
            !host_attn_n && port_switch_force_off && emu_profile_remove &&
            !data_line_switch_disable && !bus_monitor_stop;
   endproperty
   a_rd_switch: assert property (p_rd_switch) else $error("disconnect action wrong"); // [R7]

   property p_bypass_off;
      @(posedge clock) disable iff (sys_rst)
         hit_limit && (action_q == CRC_ACT_RPT_DISC) && !wr_ctrl |=>
            bypass_switch_block && port_switch_force_off;
   endproperty
   a_bypass_off: assert property (p_bypass_off) else $error("bypass not blocked"); // [R9]

   property p_sleep;
      @(posedge clock) disable iff (sys_rst)
         reached_q && (action_q == CRC_ACT_DISC_SLEEP) |->
            sleep_request && data_line_switch_disable && bus_monitor_stop &&
            ctl_pins_ignored && host_attn_n;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep action wrong"); // [R10]

   property p_hold;
      @(posedge clock) disable iff (sys_rst)
         held && !rst_evt && !disable_evt |=> held && reached_q;
   endproperty
   a_hold: assert property (p_hold) else $error("held action dropped"); // [R12]

   property p_reset_release;
      @(posedge clock) disable iff (sys_rst)
         recover |=> !reached_q && host_attn_n && (state_q == CRC_ST_IDLE);
   endproperty
   a_reset_release: assert property (p_reset_release) else $error("recovery incomplete"); // [R13]

   property p_idle_off;
      @(posedge clock) disable iff (sys_rst)
         (state_q == CRC_ST_RUN) && !active_state |=> (state_q == CRC_ST_IDLE);
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("ran outside Active"); // [R2]

   property p_flag_set;
      @(posedge clock) disable iff (sys_rst) hit_limit |=> reached_q && held;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set"); // [R22]

   property p_unchanged;
      @(posedge clock) disable iff (sys_rst)
         check_evt && !pins_changed |=> resume_prev_state && !emu_restart && !power_state_reeval;
   endproperty
   a_unchanged: assert property (p_unchanged) else $error("quiet resume failed"); // [R18]

   property p_changed;
      @(posedge clock) disable iff (sys_rst)
         check_evt && pins_changed && pins_sync_q[`CRC_PIN_EMU] |=>
            power_state_reeval && emu_restart ##1 !emu_restart;
   endproperty
   a_changed: assert property (p_changed) else $error("emulation not restarted"); // [R17]
endmodule // crc_top

// File: sim/crc_host.sv
// Host model: AHB-Lite master that programs the rationing registers.
// Assumes one slave whose hreadyout is fed back as hready.
module crc_host (
   input wire logic clock,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {hsel, haddr, htrans, hwrite, hwdata} = '0;
   // ------------------------------------------------------------------------
   // Single word transfer
   // ------------------------------------------------------------------------
   // The address phase stands until hready, then the data phase likewise.
   // The host is the party that supplies the limit word through this.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clock); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule // crc_host

// File: sim/crc_top_test.sv
// Bench for the charge rationing controller, short tick and mAh counts.
// Assumes crc_regs.svh on the include path and crc_host as bus master.
`include "crc_regs.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s exp %h got %h", n, e, s); end end
module crc_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0;
   logic sys_rst = 1;
   logic hready, hresp, hsel, hwrite;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, q, c;
   logic [11:0] cur = 0;
   logic act = 0, rem = 0, att = 0;
   logic [4:0] pins = 0;
   logic attn_n, emu_rm, sw_off, byp, slp, dls, mon, ign, reeval, resume, emu_rs;
   logic [2:0] seen = 0;
   logic clr_q = 0;
   int n_mismatch = 0, checks = 0, cyc = 0;
   always #20 clock = ~clock;
   // Pulses are caught sticky so a one cycle output is never missed.
   always @(posedge clock) seen <= clr_q ? 3'h0 : (seen | {emu_rs, reeval, resume});
   crc_top #(.TICK_CYCLES(4), .TICKS_PER_MAH(10)) dut (
      .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .current_ma(cur),
      .active_state(act), .removal_event(rem), .attach_event(att),
      .mode_select_lo(pins[0]), .mode_select_hi(pins[1]), .emulation_enable_pin(pins[2]),
      .standby_bypass_ctl(pins[3]), .port_power_enable_pin(pins[4]), .host_attn_n(attn_n),
      .emu_profile_remove(emu_rm), .port_switch_force_off(sw_off),
      .bypass_switch_block(byp), .sleep_request(slp), .data_line_switch_disable(dls),
      .bus_monitor_stop(mon), .ctl_pins_ignored(ign), .power_state_reeval(reeval),
      .resume_prev_state(resume), .emu_restart(emu_rs));
   crc_host host (.clock(clock), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a);
      host.xfer(1'b0, a, 32'h0, q);
   endtask
   task automatic clr;
      clr_q <= 1'b1;
      @(posedge clock);
      clr_q <= 1'b0;
   endtask
   // Clears the charge, runs 10 mA per tick to a 3 mAh limit, then stops current.
   task automatic hit(input logic [1:0] a);
      int i = 0;
      cur <= 12'd10;
      act <= 1'b1;
      wr(`CRC_OFS_LIMIT, 32'd3);
      wr(`CRC_OFS_CTRL, {28'h0, 1'b1, a, 1'b1});
      rd(`CRC_OFS_STATUS);
      while (q[0] !== 1'b1 && i < 100) begin
         rd(`CRC_OFS_STATUS);
         i++;
      end
      cur <= 12'd0;
      `CHK("flag", 1'b1, q[0])
      `CHK("state", 2'h3, q[3:2])
      rd(`CRC_OFS_CHARGE);
      `CHK("charge", 1'b1, q[15:0] >= 16'd3)
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ------------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------------
   task automatic t_rst;
      `CHK("outs", 12'h400, {hresp, attn_n, emu_rm, sw_off, byp, slp, dls, mon, ign, reeval, resume, emu_rs})
      rd(`CRC_OFS_CTRL);
      `CHK("ctrl", 32'h2, q)
      rd(`CRC_OFS_LIMIT);
      `CHK("limit", 32'hffff, q)
      rd(8'h10);
      `CHK("unmapped", 32'h0, q)
      $display("t_rst done");
   endtask
   task automatic t_rd;
      hit(2'h1);
      `CHK("attn", 1'b0, attn_n)
      `CHK("off", 3'h7, {emu_rm, sw_off, byp})
      `CHK("dls", 3'h0, {dls, mon, slp})
      clr;
      wr(`CRC_OFS_CTRL, 32'hb);
      repeat (2) @(posedge clock);
      `CHK("resume", 3'h1, seen)
      `CHK("attn", 1'b1, attn_n)
      rd(`CRC_OFS_STATUS);
      `CHK("stat", 2'h0, q[1:0])
      rd(`CRC_OFS_CHARGE);
      `CHK("clr", 16'h0, q[15:0])
      $display("t_rd done");
   endtask
   task automatic t_ds;
      hit(2'h2);
      `CHK("sleep", 7'h7e, {slp, dls, mon, ign, emu_rm, sw_off, byp})
      `CHK("attn", 1'b1, attn_n)
      pins <= 5'h05;
      repeat (4) @(posedge clock);
      `CHK("held", 2'h3, {slp, ign})
      clr;
      wr(`CRC_OFS_CTRL, 32'hd);
      repeat (2) @(posedge clock);
      `CHK("reeval", 3'h6, seen)
      rd(`CRC_OFS_STATUS);
      `CHK("flag", 1'b0, q[0])
      pins <= 5'h00;
      $display("t_ds done");
   endtask
   task automatic t_chg;
      hit(2'h0);
      `CHK("rep", 2'h0, {attn_n, sw_off})
      rd(`CRC_OFS_CHARGE);
      c = q;
      clr;
      wr(`CRC_OFS_CTRL, 32'h3);
      @(posedge clock);
      `CHK("rdsw", 2'h3, {sw_off, byp})
      wr(`CRC_OFS_CTRL, 32'h7);
      @(posedge clock);
      `CHK("ign", 1'b1, attn_n)
      rd(`CRC_OFS_CHARGE);
      `CHK("keep", c, q)
      `CHK("recheck", 3'h1, seen)
      rd(`CRC_OFS_STATUS);
      `CHK("hold", 1'b1, q[0])
      clr;
      wr(`CRC_OFS_CTRL, 32'hf);
      rd(`CRC_OFS_STATUS);
      `CHK("ignclr", 1'b0, q[0])
      `CHK("ignquiet", 3'h0, seen)
      hit(2'h3);
      `CHK("ignhit", 5'h10, {attn_n, emu_rm, sw_off, byp, slp})
      $display("t_chg done");
   endtask
   task automatic t_run;
      act <= 1'b0;
      cur <= 12'd10;
      wr(`CRC_OFS_LIMIT, 32'hffff);
      wr(`CRC_OFS_CTRL, 32'hb);
      repeat (20) @(posedge clock);
      rd(`CRC_OFS_STATUS);
      `CHK("idle", 2'h0, q[3:2])
      rd(`CRC_OFS_CHARGE);
      `CHK("nocharge", 16'h0, q[15:0])
      act <= 1'b1;
      repeat (40) @(posedge clock);
      clr;
      @(posedge clock) rem <= 1'b1;
      @(posedge clock) {rem, att} <= 2'h1;
      @(posedge clock) att <= 1'b0;
      repeat (2) @(posedge clock);
      `CHK("attach", 1'b1, seen[2])
      rd(`CRC_OFS_CHARGE);
      `CHK("kept", 1'b1, q[15:0] != 16'h0)
      cur <= 12'd0;
      $display("t_run done");
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test;
      end
   end
   initial begin
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      t_rst;
      t_rd;
      t_ds;
      t_chg;
      t_run;
      finish_test;
   end
endmodule // crc_top_test
